/* design/sto_select.sv */
// Purpose: Safe torque off selection supervisor with AXI4-Lite registers and interrupt.
// Assumes: Contacts are closed when high; ref_clk at 200 MHz; sys_rst synchronous active high.
// Notes: Torque is withheld whenever any channel asks for the safe state.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "sto_defs.svh"
module sto_select
    import sto_pkg::*;
#(
    parameter int TOL_CYCLES = `STO_TOL_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sel_ch1_pin,
    input wire logic sel_ch2_pin,
    input wire logic drive_enable_pin,
    output logic torque_enable,
    output logic ack_terminal_one,
    output logic ack_terminal_two,
    output logic input_check_error,
    output logic off_while_enabled_error,
    output logic off_while_enabled_warning,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Parameter check
    // ****************************************
    // The timer is 32 bits wide; a zero tolerance would never allow a change.
    if (TOL_CYCLES < 1)
    begin : g_bad_tol
        $error("TOL_CYCLES must be at least one");
    end

    // ****************************************
    // State
    // ****************************************
    // Every flip-flop of the block outside the synchroniser lives in this struct.
    typedef struct packed
    {
        sto_state_e fsm;
        logic [31:0] timer;
        logic [1:0] cfg;
        logic [`STO_EV_WIDTH-1:0] events;
        logic [`STO_EV_WIDTH-1:0] mask;
        logic [7:0] history;
        logic err_latch;
        logic owe_err;
        logic owe_warn;
        logic selected;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic bresp_err;
        logic rvalid;
        logic [31:0] rdata;
        logic rresp_err;
    } sto_state_s;

    sto_state_s state_reg;
    sto_state_s state_next;
    logic [2:0] pins_sync; // Synchronised ch1, ch2, drive enable.
    sto_chan_s chan; // Channels after the two flops.
    logic drive_en; // Synchronised drive enable.
    logic ch1_sel; // Channel 1 asks for torque off.
    logic ch2_sel; // Channel 2 asks for torque off.
    logic agree; // Both channels say the same.
    logic any_sel; // Either channel asks for torque off.
    logic owe_event; // Selection arriving while drive is enabled.
    logic [`STO_EV_WIDTH-1:0] ev_set; // Hardware event pulses.
    logic [31:0] status_word; // Live status view.
    logic wr_fire; // Write address and data both held.
    logic rd_fire; // Read address accepted.

    // ****************************************
    // Input synchronisation
    // ****************************************
    sto_sync #(.WIDTH(3)) u_sync
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in({sel_ch1_pin, sel_ch2_pin, drive_enable_pin}),
        .sync_out(pins_sync)
    );

    assign chan = '{ch1: pins_sync[2], ch2: pins_sync[1]};
    assign drive_en = pins_sync[0];

    // Decode the register offset; used by both read and write paths.
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            `STO_OFS_CONFIG: reg_index = 3'h1;
            `STO_OFS_STATUS: reg_index = 3'h2;
            `STO_OFS_EVENTS: reg_index = 3'h3;
            `STO_OFS_MASK: reg_index = 3'h4;
            `STO_OFS_HISTORY: reg_index = 3'h5;
            default: reg_index = 3'h0;
        endcase
    endfunction

    // ****************************************
    // Channel interpretation
    // ****************************************
    // two channel selection
    // pairing by setting
    // Channel 1 is always a closed contact that opens to select. Channel 2
    // either opens too, or in the complementary pairing closes to select.
    assign ch1_sel = ~chan.ch1;
    assign ch2_sel = (sto_pair_e'(state_reg.cfg[`STO_CFG_COMPL_BIT]) == STO_PAIR_NCNO) ? chan.ch2 : ~chan.ch2;
    assign agree = (ch1_sel == ch2_sel);
    assign any_sel = ch1_sel | ch2_sel;

    assign owe_event = any_sel & ~state_reg.selected & drive_en;
    // Fault entry is taken from the registered timer, not from the next state, so the
    // event does not feed back into the next-state process that reads it.
    assign ev_set[`STO_EV_INPUT_BIT] = (state_reg.fsm == STO_DISCREP) & ~agree
        & (state_reg.timer >= 32'(TOL_CYCLES));
    assign ev_set[`STO_EV_OWE_BIT] = owe_event;
    assign ev_set[`STO_EV_SELECT_BIT] = any_sel & ~state_reg.selected;

    always_comb
    begin
        status_word = '0;
        status_word[`STO_ST_SELECTED_BIT] = state_reg.selected;
        status_word[`STO_ST_VALID_BIT] = (state_reg.fsm == STO_IDLE);
        status_word[`STO_ST_DISCREP_BIT] = (state_reg.fsm == STO_DISCREP);
        status_word[`STO_ST_ERR_BIT] = state_reg.err_latch;
        status_word[`STO_ST_OWE_ERR_BIT] = state_reg.owe_err;
        status_word[`STO_ST_OWE_WARN_BIT] = state_reg.owe_warn;
        status_word[`STO_ST_TORQUE_BIT] = torque_enable;
    end

    assign wr_fire = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;

    // ****************************************
    // Next state
    // ****************************************
    // Supervisor, diagnostics and bus slave in one pass.
    always_comb
    begin
        state_next = state_reg;
        state_next.selected = any_sel;
        case (state_reg.fsm)
            STO_IDLE:
            begin
                // First channel moved; start counting.
                if (!agree)
                begin
                    state_next.fsm = STO_DISCREP;
                    state_next.timer = 32'h0000_0001;
                end
            end
            STO_DISCREP:
            begin
                if (agree)
                begin
                    state_next.fsm = STO_IDLE;
                    state_next.timer = '0;
                end
                else if (state_reg.timer >= 32'(TOL_CYCLES))
                begin
                    state_next.fsm = STO_FAULT;
                end
                else
                begin
                    state_next.timer = state_reg.timer + 32'h0000_0001;
                end
            end
            STO_FAULT:
            begin
                // Stays invalid until the channels agree again.
                if (agree)
                begin
                    state_next.fsm = STO_IDLE;
                    state_next.timer = '0;
                end
            end
            default:
            begin
                state_next.fsm = STO_IDLE;
            end
        endcase

        if (ev_set[`STO_EV_INPUT_BIT])
        begin
            state_next.err_latch = 1'b1;
        end

        if (owe_event)
        begin
            if (state_reg.cfg[`STO_CFG_WARN_BIT])
            begin
                state_next.owe_warn = 1'b1;
            end
            else
            begin
                state_next.owe_err = 1'b1;
            end
            if (state_reg.history != 8'hFF)
            begin
                state_next.history = state_reg.history + 8'h01;
            end
        end
        else if (!drive_en)
        begin
            state_next.owe_warn = 1'b0;
        end

        // Write channel capture; address and data in either order.
        if (s_axi_awvalid && s_axi_awready)
        begin
            state_next.aw_got = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        // Events: clear by writing one, set wins over clear.
        if (wr_fire)
        begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp_err = 1'b0;
            case (reg_index(state_reg.aw_addr))
                3'h1:
                begin
                    if (state_reg.w_strb[0])
                    begin
                        state_next.cfg = state_reg.w_data[1:0];
                        // Writing the config also acknowledges latched faults; a fault of the
                        // same cycle is kept, reported in the mode that was in force.
                        state_next.err_latch = ev_set[`STO_EV_INPUT_BIT];
                        state_next.owe_err = owe_event & ~state_reg.cfg[`STO_CFG_WARN_BIT];
                    end
                end
                3'h2, 3'h5:
                begin
                    // Read only; write ignored.
                    state_next.bresp_err = 1'b0;
                end
                3'h3:
                begin
                    if (state_reg.w_strb[0])
                    begin
                        state_next.events = (state_reg.events & ~state_reg.w_data[`STO_EV_WIDTH-1:0]) | ev_set;
                    end
                end
                3'h4:
                begin
                    if (state_reg.w_strb[0])
                    begin
                        state_next.mask = state_reg.w_data[`STO_EV_WIDTH-1:0];
                    end
                end
                default:
                begin
                    state_next.bresp_err = 1'b1;
                end
            endcase
        end
        if (!(wr_fire && reg_index(state_reg.aw_addr) == 3'h3 && state_reg.w_strb[0]))
        begin
            state_next.events = state_next.events | ev_set;
        end
        if (state_reg.bvalid && s_axi_bready)
        begin
            state_next.bvalid = 1'b0;
        end

        // Read channel.
        if (rd_fire)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp_err = 1'b0;
            case (reg_index(s_axi_araddr))
                3'h1: state_next.rdata = {30'h0, state_reg.cfg};
                3'h2: state_next.rdata = status_word;
                3'h3: state_next.rdata = {29'h0, state_reg.events};
                3'h4: state_next.rdata = {29'h0, state_reg.mask};
                3'h5: state_next.rdata = {24'h0, state_reg.history};
                default:
                begin
                    state_next.rdata = '0;
                    state_next.rresp_err = 1'b1;
                end
            endcase
        end
        else if (state_reg.rvalid && s_axi_rready)
        begin
            state_next.rvalid = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
            state_reg.fsm <= STO_IDLE;
            state_reg.cfg <= `STO_CONFIG_RST;
            // The synchroniser resets to open contacts, which reads as selected; starting
            // selected avoids a false selection event just after reset.
            state_reg.selected <= 1'b1;
            state_reg.mask <= `STO_MASK_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // immediate torque cut
    // Any selecting channel, even one still in discrepancy, removes torque; no ramp.
    assign torque_enable = drive_en & ~state_reg.selected & (state_reg.fsm != STO_FAULT);
    // changeover feedback contact
    // Terminal one closes in the safe state, terminal two otherwise.
    assign ack_terminal_one = ~torque_enable;
    assign ack_terminal_two = torque_enable;
    assign input_check_error = state_reg.err_latch;
    assign off_while_enabled_error = state_reg.owe_err;
    assign off_while_enabled_warning = state_reg.owe_warn;
    assign irq = |(state_reg.events & state_reg.mask);
    assign s_axi_awready = ~state_reg.aw_got & ~state_reg.bvalid;
    assign s_axi_wready = ~state_reg.w_got & ~state_reg.bvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp_err ? 2'h2 : 2'h0;
    assign s_axi_arready = ~state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp_err ? 2'h2 : 2'h0;

    // ****************************************
    // Assertions
    // ****************************************
    sequence owe_seen_s;
        owe_event;
    endsequence
    sequence owe_flag_s;
        off_while_enabled_error || off_while_enabled_warning;
    endsequence

    torque_cut_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        any_sel |=> !torque_enable)
        else $error("torque not cut after selection");
    owe_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        owe_seen_s |=> owe_flag_s)
        else $error("off while enabled not flagged");
    owe_kind_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        owe_event && state_reg.cfg[`STO_CFG_WARN_BIT] && !wr_fire |=> off_while_enabled_warning)
        else $error("warning variant not used");
    warn_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !drive_en && !owe_event |=> !off_while_enabled_warning)
        else $error("warning did not clear");
    history_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        owe_event && state_reg.history != 8'hFF |=> state_reg.history == $past(state_reg.history) + 8'h01)
        else $error("history not recorded");
    discrep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg.fsm == STO_IDLE && !agree |=> state_reg.fsm == STO_DISCREP && state_reg.timer == 32'h1)
        else $error("timer did not start");
    tol_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg.fsm == STO_DISCREP && !agree && state_reg.timer >= 32'(TOL_CYCLES) |=> input_check_error)
        else $error("tolerance expiry not flagged");
    feedback_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ack_terminal_one != ack_terminal_two)
        else $error("feedback contact not changeover");
    status_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rd_fire && s_axi_araddr == `STO_OFS_STATUS |=> s_axi_rdata == $past(status_word))
        else $error("status read mismatch");
endmodule

/* design/sto_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the torque off selector.
// Assumes: 200 MHz ref_clk.
// Notes: Definitions only.
`ifndef STO_DEFS_SVH
`define STO_DEFS_SVH
// Register byte offsets.
`define STO_OFS_CONFIG 8'h00
`define STO_OFS_STATUS 8'h04
`define STO_OFS_EVENTS 8'h08
`define STO_OFS_MASK 8'h0C
`define STO_OFS_HISTORY 8'h10
// Config fields.
`define STO_CFG_COMPL_BIT 0
`define STO_CFG_WARN_BIT 1
// Status fields.
`define STO_ST_SELECTED_BIT 0
`define STO_ST_VALID_BIT 1
`define STO_ST_DISCREP_BIT 2
`define STO_ST_ERR_BIT 3
`define STO_ST_OWE_ERR_BIT 4
`define STO_ST_OWE_WARN_BIT 5
`define STO_ST_TORQUE_BIT 6
// Event fields.
`define STO_EV_INPUT_BIT 0
`define STO_EV_OWE_BIT 1
`define STO_EV_SELECT_BIT 2
`define STO_EV_WIDTH 3
// Reset values.
`define STO_CONFIG_RST 2'h0
`define STO_MASK_RST 3'h0
// Discrepancy tolerance.
`define STO_TOL_MS 100
`define STO_CLK_MHZ 200
`define STO_TOL_CYCLES (`STO_TOL_MS * 1000 * `STO_CLK_MHZ)
`endif

/* design/sto_pkg.sv */
// Purpose: Types shared by the torque off selector.
// Assumes: Nothing.
// Notes: Constants live in sto_defs.svh.
package sto_pkg;
    // Interpretation of the two selection contacts.
    typedef enum logic [0:0] {STO_PAIR_NCNC = 1'b0, STO_PAIR_NCNO = 1'b1} sto_pair_e;
    // Supervisor states.
    typedef enum logic [1:0]
    {
        STO_IDLE = 2'b00,
        STO_DISCREP = 2'b01,
        STO_FAULT = 2'b10
    } sto_state_e;
    // Synchronised selection channels.
    typedef struct packed
    {
        logic ch1;
        logic ch2;
    } sto_chan_s;
endpackage

/* design/sto_sync.sv */
// Purpose: Two flop synchroniser for the selection contacts and drive enable.
// Assumes: Inputs are asynchronous pins.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module sto_sync
    import sto_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // All state of the synchroniser.
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sto_sync_s;

    sto_sync_s state_reg;
    sto_sync_s state_next;

    // Width must be at least one.
    if (WIDTH < 1)
    begin : g_bad
        $error("sto_sync WIDTH must be positive");
    end

    // Shift the pins through two stages.
    always_comb
    begin
        state_next.meta = async_in;
        state_next.held = state_reg.meta;
    end

    // Register the copy; reset to contacts open.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.held;
endmodule

/* test/sto_switch_model.sv */
// Purpose: Model of the selecting switch that drives both selection contacts.
// Assumes: Channel 1 is normally closed; channel 2 follows the chosen pairing.
// Notes: Channel 2 follows channel 1 after skew cycles, so a discrepancy can be staged.
`timescale 1ns/1ps
// ****************************************
// Switch model
// ****************************************
module sto_switch_model
(
    input wire logic ref_clk,
    input wire logic sel_req,
    input wire logic pair_ncno,
    input wire logic [7:0] skew,
    output logic ch1,
    output logic ch2
);
    // Selected state of each channel.
    logic s1 = 1'b0;
    logic s2 = 1'b0;
    // Cycles that channel 2 has lagged so far.
    int cnt = 0;

    always @(posedge ref_clk)
    begin
        s1 <= sel_req;
        if (s2 == sel_req)
            cnt <= 0;
        else if (cnt >= int'(skew))
            s2 <= sel_req;
        else
            cnt <= cnt + 1;
    end

    // Contacts open to select; a normally open second contact closes instead.
    assign ch1 = ~s1;
    assign ch2 = pair_ncno ? s2 : ~s2;
endmodule

/* test/tb_top.sv */
// Purpose: Self-checking bench of the torque off selector.
// Assumes: Tolerance shortened to 50 cycles so a discrepancy fits a short run.
// Notes: Bus signals are sampled on the falling edge, where they are settled.
`timescale 1ns/1ps
`include "sto_defs.svh"
// ****************************************
// Bench top
// ****************************************
module tb_top
    import sto_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    // Partner requests and drive enable.
    logic sel_req = 1'b0;
    logic pair_ncno = 1'b0;
    logic drv_en = 1'b0;
    logic [7:0] skew = 8'h00;
    logic ch1, ch2, torque_en, ack1, ack2, in_err, owe_err, owe_warn, irq;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    int err_total = 0;
    int compares = 0;

    always #2.5 ref_clk = ~ref_clk;

    sto_switch_model sw_u (.ref_clk(ref_clk), .sel_req(sel_req), .pair_ncno(pair_ncno), .skew(skew),
        .ch1(ch1), .ch2(ch2));

    sto_select #(.TOL_CYCLES(50)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .sel_ch1_pin(ch1),
        .sel_ch2_pin(ch2), .drive_enable_pin(drv_en), .torque_enable(torque_en), .ack_terminal_one(ack1),
        .ack_terminal_two(ack2), .input_check_error(in_err), .off_while_enabled_error(owe_err),
        .off_while_enabled_warning(owe_warn), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // Compare a single pin.
    task chk_pin(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Compare a register word.
    task chk_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Print counts and verdict; the one place the run ends.
    task give_verdict;
        $display("errors=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Wait n edges, then let their updates land.
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Set the selection request and drive enable on a rising edge.
    task go(input logic s, input logic e);
        @(posedge ref_clk);
        sel_req <= s;
        drv_en <= e;
    endtask

    // Bus write: address and data offered together, each released when taken.
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(negedge ref_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge ref_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tb)
            begin
                bready <= 1'b0;
                return;
            end
        end
    endtask

    // Bus read: data and response land in d and r.
    task rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(negedge ref_clk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (ta)
                arvalid <= 1'b0;
            if (tr)
            begin
                rready <= 1'b0;
                return;
            end
        end
    endtask

    // Reset values and an unmapped address.
    task t_regs;
        rd(`STO_OFS_CONFIG);
        chk_word(d, 32'h0);
        rd(`STO_OFS_MASK);
        chk_word(d, 32'h0);
        rd(8'h20);
        chk_word({30'h0, r}, 32'h2);
        chk_word(d, 32'h0);
        wr(8'h20, 32'h0);
        chk_word({30'h0, r}, 32'h2);
    endtask

    // Plain selection with the drive off; interrupt raised, masked and cleared.
    task t_select;
        go(1'b1, 1'b0);
        cyc(6);
        chk_pin(torque_en, 1'b0);
        chk_pin(ack1, 1'b1);
        chk_pin(ack2, 1'b0);
        rd(`STO_OFS_STATUS);
        chk_word(d & 32'h43, 32'h3);
        wr(`STO_OFS_MASK, 32'h4);
        cyc(1);
        chk_pin(irq, 1'b1);
        wr(`STO_OFS_EVENTS, 32'h4);
        cyc(1);
        chk_pin(irq, 1'b0);
        wr(`STO_OFS_MASK, 32'h0);
        go(1'b0, 1'b0);
        cyc(6);
        rd(`STO_OFS_STATUS);
        chk_word(d & 32'h3, 32'h2);
    endtask

    // Selection while enabled, in error or warning mode; hist is the expected count.
    task t_owe(input logic warn, input logic [31:0] hist);
        wr(`STO_OFS_CONFIG, {30'h0, warn, 1'b0});
        go(1'b0, 1'b1);
        cyc(6);
        chk_pin(torque_en, 1'b1);
        go(1'b1, 1'b1);
        cyc(4);
        chk_pin(torque_en, 1'b0);
        chk_pin(owe_err, ~warn);
        chk_pin(owe_warn, warn);
        go(1'b1, 1'b0);
        cyc(5);
        chk_pin(owe_warn, 1'b0);
        chk_pin(owe_err, ~warn);
        rd(`STO_OFS_HISTORY);
        chk_word(d, hist);
        go(1'b0, 1'b0);
        cyc(6);
        wr(`STO_OFS_CONFIG, 32'h0);
        cyc(1);
        chk_pin(owe_err, 1'b0);
    endtask

    // Channel 2 lags past the tolerance.
    task t_discrep;
        @(posedge ref_clk);
        skew <= 8'h50;
        go(1'b1, 1'b0);
        cyc(40);
        chk_pin(in_err, 1'b0);
        rd(`STO_OFS_STATUS);
        chk_word(d & 32'h6, 32'h4);
        cyc(30);
        chk_pin(in_err, 1'b1);
        rd(`STO_OFS_EVENTS);
        chk_word(d & 32'h1, 32'h1);
        cyc(20);
        @(posedge ref_clk);
        skew <= 8'h00;
        go(1'b0, 1'b0);
        cyc(6);
        wr(`STO_OFS_CONFIG, 32'h0);
        wr(`STO_OFS_EVENTS, 32'h7);
        cyc(1);
        chk_pin(in_err, 1'b0);
    endtask

    // Complementary pairing: legal levels raise no error.
    task t_ncno;
        wr(`STO_OFS_CONFIG, 32'h1);
        @(posedge ref_clk);
        pair_ncno <= 1'b1;
        go(1'b1, 1'b0);
        cyc(6);
        rd(`STO_OFS_STATUS);
        chk_word(d & 32'h3, 32'h3);
        go(1'b0, 1'b0);
        cyc(6);
        chk_pin(in_err, 1'b0);
        chk_pin(ack1, 1'b1);
    endtask

    // Main sequence.
    initial
    begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_select;
        t_owe(1'b0, 32'h1);
        t_owe(1'b1, 32'h2);
        t_discrep;
        t_ncno;
        give_verdict;
    end

    // Watchdog; the whole sequence takes well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        give_verdict;
    end
endmodule
